/* rtl/ubdr_defs.svh */
/*
 * Register offsets, field positions, reset values and divide ratios of the
 * baud generator and data register block.
 * Assumes inclusion by bare name from rtl/ files.
 */
`ifndef UBDR_DEFS_SVH
`define UBDR_DEFS_SVH

// ***************************************************************
// register byte offsets
// ***************************************************************
`define UBDR_OFS_BAUD_CONTROL 8'h00
`define UBDR_OFS_RECEIVE_DATA 8'h04
`define UBDR_OFS_TRANSMIT_DATA 8'h08
`define UBDR_OFS_DIVISOR_LOW 8'h0c
`define UBDR_OFS_DIVISOR_HIGH 8'h10
`define UBDR_OFS_RECEIVE_CTRL 8'h14
`define UBDR_OFS_TRANSMIT_CTRL 8'h18

// ***************************************************************
// field positions
// ***************************************************************
`define UBDR_BC_AUTO_RATE 0
`define UBDR_BC_WAKE 1
`define UBDR_BC_WIDE 3
`define UBDR_BC_POLARITY 4
`define UBDR_BC_RX_IDLE 6
`define UBDR_BC_RATE_OVF 7
`define UBDR_RS_NINTH 0
`define UBDR_TS_NINTH 0
`define UBDR_TS_SHIFT_EMPTY 1
`define UBDR_TS_HIGH_SPEED 2
`define UBDR_TS_SYNC 4

// ***************************************************************
// reset values and ratios
// ***************************************************************
`define UBDR_RST_BYTE 8'h00
`define UBDR_RATIO_LOW 7'h40
`define UBDR_RATIO_MID 7'h10
`define UBDR_RATIO_SYNC 7'h04
`define UBDR_SYNC_CHAR 8'h55
`define UBDR_AUTO_EDGES 4'h5

`endif

/* rtl/ubdr_pkg.sv */
/*
 * Types shared by the baud generator and data register block.
 * Assumes the defs header is compiled alongside.
 */
package ubdr_pkg;
   // auto-rate measurement progress
   typedef enum logic [1:0] {
      UBDR_AB_IDLE = 2'b00,
      UBDR_AB_WAIT = 2'b01,
      UBDR_AB_MEASURE = 2'b10
   } ubdr_ab_type;
endpackage

/* rtl/ubdr_core.sv */
/*
 * Baud generator, mode control, and double-buffered receive and transmit
 * data registers of a serial port, reached over AHB-Lite.
 * Assumes neighbouring shifters exchange characters through valid/ready
 * ports and that all pin inputs are synchronous to hclk.
 */
`timescale 1ns/1ps
`include "ubdr_defs.svh"

// Overview of operation
// RQ1: receive register holds low eight bits
// RQ2: received character double-buffered with ninth bit
// RQ3: transmit character double-buffered with ninth bit
// RQ4: divisor low write restarts baud counter
// RQ5: divisor high write restarts baud counter
// RQ6: high byte ignored unless wide select
// RQ7: wide divisor is high:low concatenation
// RQ8: async low speed eight-bit divides 64(n+1)
// RQ9: async wide low speed divides 16(n+1)
// RQ10: synchronous mode divides 4(n+1)
// RQ11: async wide high speed matches synchronous
// RQ12: polarity sets clock or transmit idle
// RQ13: auto-rate measures 55h, then self-clears
// RQ14: wake flags falling edge, clears on rise
// RQ15: async high speed eight-bit divides 16(n+1)
// RQ16: partner sends sync character first
module ubdr_core (
   // clock, reset, enable
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clk_en,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // receive shifter side
   input wire logic rx_valid,
   input wire logic [8:0] rx_char,
   output logic rx_ready,
   input wire logic rx_pin,
   input wire logic rx_busy,
   // transmit shifter side
   output logic tx_valid,
   output logic [8:0] tx_char,
   input wire logic tx_ready,
   input wire logic tx_shift_empty,
   // baud tick, idle level, wake event
   output logic baud_tick,
   output logic idle_level,
   output logic wake_event
);
   logic wr_pend, acc_ok;
   logic [7:0] wr_addr;
   logic [7:0] baud_control, divisor_low, divisor_high, tx_ctrl, rx_ctrl;
   logic [15:0] divisor, base_cnt;
   logic [6:0] ratio, pre_cnt;
   logic [8:0] rxb [0:1];
   logic [1:0] rx_cnt;
   logic rx_rd_ptr, rx_wr_ptr;
   logic [8:0] txb [0:1];
   logic [1:0] tx_cnt;
   logic tx_rd_ptr, tx_wr_ptr;
   logic rx_q, pop_rx, push_tx, rd_rx;
   logic [3:0] ab_edges;
   logic [15:0] ab_count;
   ubdr_pkg::ubdr_ab_type ab_state;
   logic sync_mode, wide, high_speed;

   // ***************************************************************
   // bus slave
   // ***************************************************************
   assign acc_ok = hsel && hready && htrans[1] && clk_en;
   assign hreadyout = 1'b1; // zero wait states, so no stall logic needed
   assign hresp = 1'b0;

   // latch write address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
      end else if (clk_en) begin
         wr_pend <= acc_ok && hwrite;
         if (acc_ok) begin
            wr_addr <= haddr;
         end
      end
   end

   assign rd_rx = acc_ok && !hwrite && haddr == `UBDR_OFS_RECEIVE_DATA;

   // read mux registered in the address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (clk_en && acc_ok && !hwrite) begin
         unique case (haddr)
            `UBDR_OFS_BAUD_CONTROL: hrdata <= {24'h000000, baud_control};
            `UBDR_OFS_RECEIVE_DATA: hrdata <= {24'h000000, rxb[rx_rd_ptr][7:0]}; // RQ1
            `UBDR_OFS_TRANSMIT_DATA: hrdata <= {24'h000000, txb[tx_wr_ptr][7:0]};
            `UBDR_OFS_DIVISOR_LOW: hrdata <= {24'h000000, divisor_low};
            `UBDR_OFS_DIVISOR_HIGH: hrdata <= {24'h000000, divisor_high};
            `UBDR_OFS_RECEIVE_CTRL: hrdata <= {24'h000000, rx_ctrl[7:1], rxb[rx_rd_ptr][8]};
            `UBDR_OFS_TRANSMIT_CTRL: hrdata <= {24'h000000, tx_ctrl[7:2],
                                                tx_shift_empty, tx_ctrl[0]};
            default: hrdata <= 32'h0000_0000;
         endcase
      end
   end

   // ***************************************************************
   // control registers
   // ***************************************************************
   assign sync_mode = tx_ctrl[`UBDR_TS_SYNC];
   assign wide = baud_control[`UBDR_BC_WIDE];
   assign high_speed = tx_ctrl[`UBDR_TS_HIGH_SPEED];

   // divisor bytes and control writes; no bits in this block are cleared by hardware
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         divisor_low <= `UBDR_RST_BYTE;
         divisor_high <= `UBDR_RST_BYTE;
         tx_ctrl <= `UBDR_RST_BYTE;
         rx_ctrl <= `UBDR_RST_BYTE;
      end else if (clk_en && wr_pend) begin
         unique case (wr_addr)
            `UBDR_OFS_DIVISOR_LOW: divisor_low <= hwdata[7:0];
            `UBDR_OFS_DIVISOR_HIGH: divisor_high <= hwdata[7:0];
            `UBDR_OFS_TRANSMIT_CTRL: tx_ctrl <= hwdata[7:0];
            `UBDR_OFS_RECEIVE_CTRL: rx_ctrl <= hwdata[7:0];
            default: ;
         endcase
      end
   end

   // baud control: wake and auto-rate are cleared by hardware
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         baud_control <= `UBDR_RST_BYTE;
      end else if (clk_en) begin
         baud_control[`UBDR_BC_RX_IDLE] <= !rx_busy;
         if (wr_pend && wr_addr == `UBDR_OFS_BAUD_CONTROL) begin
            baud_control[`UBDR_BC_WIDE] <= hwdata[`UBDR_BC_WIDE];
            baud_control[`UBDR_BC_POLARITY] <= hwdata[`UBDR_BC_POLARITY];
            baud_control[`UBDR_BC_WAKE] <= hwdata[`UBDR_BC_WAKE];
            baud_control[`UBDR_BC_AUTO_RATE] <= hwdata[`UBDR_BC_AUTO_RATE];
            baud_control[`UBDR_BC_RATE_OVF] <= hwdata[`UBDR_BC_RATE_OVF];
         end
         if (baud_control[`UBDR_BC_WAKE] && !sync_mode && !rx_q && rx_pin) begin
            baud_control[`UBDR_BC_WAKE] <= 1'b0; // RQ14
         end
         if (ab_state == ubdr_pkg::UBDR_AB_MEASURE && ab_edges == `UBDR_AUTO_EDGES) begin
            baud_control[`UBDR_BC_AUTO_RATE] <= 1'b0; // RQ13
         end
         if (ab_state == ubdr_pkg::UBDR_AB_MEASURE && &ab_count) begin
            baud_control[`UBDR_BC_RATE_OVF] <= 1'b1;
         end
      end
   end

   // ***************************************************************
   // baud generator
   // ***************************************************************
   // high byte dropped unless wide
   assign divisor = wide ? {divisor_high, divisor_low} // RQ7
                         : {8'h00, divisor_low}; // RQ6

   // ratio selection per mode
   always_comb begin
      if (sync_mode || (wide && high_speed)) begin
         ratio = `UBDR_RATIO_SYNC; // RQ10 RQ11
      end else if (wide || high_speed) begin
         ratio = `UBDR_RATIO_MID; // RQ9 RQ15
      end else begin
         ratio = `UBDR_RATIO_LOW; // RQ8
      end
   end

   // prescale by ratio then count n+1; any divisor write restarts
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pre_cnt <= 7'h00;
         base_cnt <= 16'h0000;
         baud_tick <= 1'b0;
      end else if (clk_en) begin
         baud_tick <= 1'b0;
         if (wr_pend && (wr_addr == `UBDR_OFS_DIVISOR_LOW
                         || wr_addr == `UBDR_OFS_DIVISOR_HIGH)) begin
            pre_cnt <= 7'h00; // RQ4 RQ5
            base_cnt <= 16'h0000;
         end else if (pre_cnt != ratio - 7'h01) begin
            pre_cnt <= pre_cnt + 7'h01;
         end else begin
            pre_cnt <= 7'h00;
            if (base_cnt >= divisor) begin
               base_cnt <= 16'h0000;
               baud_tick <= 1'b1;
            end else begin
               base_cnt <= base_cnt + 16'h0001;
            end
         end
      end
   end

   // idle level of shift clock or transmit line
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         idle_level <= 1'b1;
      end else if (clk_en) begin
         idle_level <= sync_mode ? baud_control[`UBDR_BC_POLARITY] // RQ12
                                 : !baud_control[`UBDR_BC_POLARITY];
      end
   end

   // ***************************************************************
   // wake and auto-rate
   // ***************************************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_q <= 1'b1;
         wake_event <= 1'b0;
      end else if (clk_en) begin
         rx_q <= rx_pin;
         wake_event <= baud_control[`UBDR_BC_WAKE] && !sync_mode
                       && rx_q && !rx_pin; // RQ14
      end
   end

   // count clocks across the five falling edges of the sync field
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ab_state <= ubdr_pkg::UBDR_AB_IDLE;
         ab_edges <= 4'h0;
         ab_count <= 16'h0000;
      end else if (clk_en) begin
         unique case (ab_state)
            ubdr_pkg::UBDR_AB_IDLE: begin
               ab_edges <= 4'h0;
               ab_count <= 16'h0000;
               if (baud_control[`UBDR_BC_AUTO_RATE] && !sync_mode) begin
                  ab_state <= ubdr_pkg::UBDR_AB_WAIT;
               end
            end
            ubdr_pkg::UBDR_AB_WAIT: begin
               if (rx_q && !rx_pin) begin // RQ16
                  ab_state <= ubdr_pkg::UBDR_AB_MEASURE;
                  ab_edges <= 4'h1;
               end
            end
            ubdr_pkg::UBDR_AB_MEASURE: begin
               if (!(&ab_count)) begin
                  ab_count <= ab_count + 16'h0001;
               end
               if (rx_q && !rx_pin) begin
                  ab_edges <= ab_edges + 4'h1;
               end
               if (ab_edges == `UBDR_AUTO_EDGES) begin
                  ab_state <= ubdr_pkg::UBDR_AB_IDLE; // RQ13
               end
            end
            default: ab_state <= ubdr_pkg::UBDR_AB_IDLE;
         endcase
      end
   end

   // ***************************************************************
   // two-entry receive and transmit buffers
   // ***************************************************************
   assign rx_ready = rx_cnt != 2'd2;
   assign pop_rx = rd_rx && rx_cnt != 2'd0;
   assign push_tx = wr_pend && wr_addr == `UBDR_OFS_TRANSMIT_DATA && tx_cnt != 2'd2;
   assign tx_valid = tx_cnt != 2'd0;
   assign tx_char = txb[tx_rd_ptr];

   // receive buffer keeps a finished character while the next shifts in
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rxb[0] <= 9'h000;
         rxb[1] <= 9'h000;
         rx_cnt <= 2'd0;
         rx_rd_ptr <= 1'b0;
         rx_wr_ptr <= 1'b0;
      end else if (clk_en) begin
         if (rx_valid && rx_ready) begin
            rxb[rx_wr_ptr] <= rx_char; // RQ2
            rx_wr_ptr <= !rx_wr_ptr;
         end
         if (pop_rx) begin
            rx_rd_ptr <= !rx_rd_ptr;
         end
         rx_cnt <= rx_cnt + {1'b0, rx_valid && rx_ready} - {1'b0, pop_rx};
      end
   end

   // transmit buffer; ninth bit is taken from the control register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         txb[0] <= 9'h000;
         txb[1] <= 9'h000;
         tx_cnt <= 2'd0;
         tx_rd_ptr <= 1'b0;
         tx_wr_ptr <= 1'b0;
      end else if (clk_en) begin
         if (push_tx) begin
            txb[tx_wr_ptr] <= {tx_ctrl[`UBDR_TS_NINTH], hwdata[7:0]}; // RQ3
            tx_wr_ptr <= !tx_wr_ptr;
         end
         if (tx_valid && tx_ready) begin
            tx_rd_ptr <= !tx_rd_ptr;
         end
         tx_cnt <= tx_cnt + {1'b0, push_tx} - {1'b0, tx_valid && tx_ready};
      end
   end

   // ***************************************************************
   // checks
   // ***************************************************************
   sequence s_div_write;
      clk_en && wr_pend && (wr_addr == `UBDR_OFS_DIVISOR_LOW
                            || wr_addr == `UBDR_OFS_DIVISOR_HIGH);
   endsequence

   a_restart_counter: assert property (@(posedge hclk) disable iff (!hresetn) // RQ4
      s_div_write |=> pre_cnt == 7'h00 && base_cnt == 16'h0000 && !baud_tick)
      else $error("divisor write did not restart counter");
   a_narrow_divisor: assert property (@(posedge hclk) disable iff (!hresetn) // RQ6
      !wide |-> divisor[15:8] == 8'h00)
      else $error("high byte used without wide select");
   a_ratio_low: assert property (@(posedge hclk) disable iff (!hresetn) // RQ8
      !sync_mode && !wide && !high_speed |-> ratio == 7'h40)
      else $error("low speed ratio wrong");
   a_ratio_mid: assert property (@(posedge hclk) disable iff (!hresetn) // RQ9
      !sync_mode && (wide ^ high_speed) |-> ratio == 7'h10)
      else $error("mid ratio wrong");
   a_ratio_sync: assert property (@(posedge hclk) disable iff (!hresetn) // RQ10
      sync_mode || (wide && high_speed) |-> ratio == 7'h04)
      else $error("sync ratio wrong");
   a_tick_spacing: assert property (@(posedge hclk) disable iff (!hresetn) // RQ10
      clk_en && baud_tick |=> (!baud_tick || !clk_en) [*3])
      else $error("tick spacing too short");
   a_wake_pulse: assert property (@(posedge hclk) disable iff (!hresetn) // RQ14
      wake_event |-> $past(rx_q) && !rx_q)
      else $error("wake without falling edge");
   a_tx_no_loss: assert property (@(posedge hclk) disable iff (!hresetn) // RQ3
      clk_en && push_tx && !(tx_valid && tx_ready) |=> tx_cnt == $past(tx_cnt) + 2'd1)
      else $error("transmit write lost");
   a_rx_held: assert property (@(posedge hclk) disable iff (!hresetn) // RQ2
      clk_en && rx_cnt != 2'd0 && !pop_rx |=> rxb[rx_rd_ptr] == $past(rxb[rx_rd_ptr]))
      else $error("held character overwritten");
   a_idle_level: assert property (@(posedge hclk) disable iff (!hresetn) // RQ12
      clk_en && sync_mode |=> idle_level == $past(baud_control[`UBDR_BC_POLARITY]))
      else $error("shift clock idle level wrong");
   // hardware clears must win over a software write in the same cycle
   a_wake_clear: assert property (@(posedge hclk) disable iff (!hresetn) // RQ14
      clk_en && baud_control[`UBDR_BC_WAKE] && !sync_mode && !rx_q && rx_pin
      |=> !baud_control[`UBDR_BC_WAKE])
      else $error("wake enable not cleared on rising edge");
   a_auto_clear: assert property (@(posedge hclk) disable iff (!hresetn) // RQ13
      clk_en && ab_state == ubdr_pkg::UBDR_AB_MEASURE && ab_edges == `UBDR_AUTO_EDGES
      |=> !baud_control[`UBDR_BC_AUTO_RATE])
      else $error("auto-rate enable not cleared");
   // a full buffer refuses the offer rather than overwrite a held character
   a_rx_refuse: assert property (@(posedge hclk) disable iff (!hresetn) // RQ2
      clk_en && rx_valid && !rx_ready && !pop_rx |=> rx_cnt == 2'd2
      && rx_wr_ptr == $past(rx_wr_ptr))
      else $error("full receive buffer took a character");
   // a low enable must hold every counter and register
   a_enable_freeze: assert property (@(posedge hclk) disable iff (!hresetn)
      !clk_en |=> $stable(baud_control) && $stable(pre_cnt) && $stable(base_cnt)
      && $stable(rx_cnt) && $stable(tx_cnt) && $stable(divisor_low))
      else $error("state moved while enable low");
endmodule

/* bench/ubdr_shifter_model.sv */
/*
 * Behavioural shifter side of the baud and data register block: offers
 * received characters, drains transmit characters with an optional stall,
 * and drives the receive pin with framed characters.
 * Assumes one hclk domain and a bench that calls its tasks.
 */
`timescale 1ns/1ps

// ***************************************************************
// shifter model
// ***************************************************************
module ubdr_shifter_model (
   // clock
   input wire logic hclk,
   // receive side
   output logic rx_valid,
   output logic [8:0] rx_char,
   input wire logic rx_ready,
   output logic rx_pin,
   output logic rx_busy,
   // transmit side
   input wire logic tx_valid,
   input wire logic [8:0] tx_char,
   output logic tx_ready,
   output logic tx_shift_empty
);
   logic [8:0] rx_q[$];
   logic [8:0] tx_got[$];
   logic stall = 1'b0;

   // pin idles high, as a pulled-up line would; receiver starts idle
   initial begin
      rx_valid = 1'b0;
      rx_char = 9'h000;
      rx_pin = 1'b1;
      rx_busy = 1'b0;
      tx_ready = 1'b1;
      tx_shift_empty = 1'b1;
   end

   // offer held until taken; an empty offer shows a changing pattern
   always @(posedge hclk) begin
      if (rx_valid && rx_ready) begin
         void'(rx_q.pop_front());
      end
      rx_valid <= (rx_q.size() != 0);
      rx_char <= (rx_q.size() != 0) ? rx_q[0] : ~rx_char;
   end

   // transmit drain, stall on command only
   always @(posedge hclk) begin
      if (tx_valid && tx_ready) begin
         tx_got.push_back(tx_char);
      end
      tx_ready <= !stall;
      tx_shift_empty <= 1'b1;
   end

   // queue updates kept off the rising edge to avoid racing the offer
   task automatic push(input logic [8:0] c);
      @(negedge hclk);
      rx_q.push_back(c);
   endtask

   // start low, data lsb first, stop high
   task automatic send_frame(input logic [7:0] b, input int bit_cyc);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge hclk);
         rx_pin <= f[i];
         rx_busy <= 1'b1;
         repeat (bit_cyc - 1) @(posedge hclk);
      end
      @(posedge hclk);
      rx_busy <= 1'b0;
   endtask
endmodule

/* bench/tb_usart_baud_and_data_regs.sv */
/*
 * Self-checking bench for the baud generator and data register block.
 * Assumes the core and the shifter model are compiled alongside.
 */
`timescale 1ns/1ps
`include "ubdr_defs.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb_usart_baud_and_data_regs;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, rx_valid, rx_ready;
   logic rx_pin, rx_busy, tx_valid, tx_ready, tx_shift_empty;
   logic baud_tick, idle_level, wake_event, clk_en;
   logic [7:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, rd;
   logic [8:0] rx_char, tx_char;
   // sync, high speed, wide per mode, with its divide ratio
   logic [2:0] md [6] = '{3'b000, 3'b010, 3'b001, 3'b011, 3'b100, 3'b111};
   int ratio [6] = '{64, 16, 16, 4, 4, 4};
   int fail_count = 0;
   int n_tests = 0;
   int wake_n = 0;
   int p, q;

   ubdr_core ubdr_core_i (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .rx_valid(rx_valid), .rx_char(rx_char), .rx_ready(rx_ready), .rx_pin(rx_pin),
      .rx_busy(rx_busy), .tx_valid(tx_valid), .tx_char(tx_char), .tx_ready(tx_ready),
      .tx_shift_empty(tx_shift_empty), .baud_tick(baud_tick), .idle_level(idle_level),
      .wake_event(wake_event));
   ubdr_shifter_model ubdr_shifter_model_i (.hclk(hclk), .rx_valid(rx_valid),
      .rx_char(rx_char), .rx_ready(rx_ready), .rx_pin(rx_pin), .rx_busy(rx_busy),
      .tx_valid(tx_valid), .tx_char(tx_char), .tx_ready(tx_ready),
      .tx_shift_empty(tx_shift_empty));

   // ***************************************************************
   // clock, event counter, bus tasks
   // ***************************************************************
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   // wake pulses are single cycles, so count them as they pass
   always @(posedge hclk) begin
      if (wake_event === 1'b1) wake_n <= wake_n + 1;
   end

   // one single transfer; waits on hready with a bounded count
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int t;
      t = 0;
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= wr;
      hsize <= 3'b010;
      do @(posedge hclk); while (hreadyout !== 1'b1 && ++t < 50);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1 && ++t < 50);
      rd = hrdata;
      if (t >= 50) fail_count++;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      ahb(1'b1, a, {24'h000000, d});
   endtask

   task automatic rdc(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
      ahb(1'b0, a, 32'h00000000);
      `CHK(rd[7:0] & m, e)
      `CHK(hresp, 1'b0)
   endtask

   task automatic to_tick(output int n);
      n = 0;
      do begin @(negedge hclk); n++; end while (baud_tick !== 1'b1 && n < 20000);
   endtask

   task automatic period(output int n);
      int t;
      to_tick(t);
      to_tick(n);
   endtask

   task automatic done(input string s);
      $display("test %s done", s);
   endtask

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // hang guard, well past the expected run length
   initial begin
      #900000;
      fail_count++;
      finish_test();
   end

   // ***************************************************************
   // tests
   // ***************************************************************
   initial begin
      {hsel, hwrite, haddr, htrans, hsize, hwdata} = 47'h0;
      clk_en = 1'b1;
      hresetn = 1'b0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      // reset values and unmapped place
      rdc(`UBDR_OFS_BAUD_CONTROL, 8'h40, 8'hff);
      rdc(`UBDR_OFS_RECEIVE_DATA, 8'h00, 8'hff);
      rdc(`UBDR_OFS_TRANSMIT_DATA, 8'h00, 8'hff);
      rdc(`UBDR_OFS_DIVISOR_LOW, 8'h00, 8'hff);
      rdc(`UBDR_OFS_DIVISOR_HIGH, 8'h00, 8'hff);
      wr(8'h1c, 8'hff);
      rdc(8'h1c, 8'h00, 8'hff);
      done("reset");
      // every mode with n = 2 narrow, 0x0102 wide; high byte set throughout
      wr(`UBDR_OFS_DIVISOR_LOW, 8'h02);
      wr(`UBDR_OFS_DIVISOR_HIGH, 8'h01);
      rdc(`UBDR_OFS_DIVISOR_HIGH, 8'h01, 8'hff);
      for (int i = 0; i < 6; i++) begin
         wr(`UBDR_OFS_TRANSMIT_CTRL, {3'b000, md[i][2], 1'b0, md[i][1], 2'b00});
         wr(`UBDR_OFS_BAUD_CONTROL, {3'b000, i[0], md[i][0], 3'b000});
         period(p);
         `CHK(p, ratio[i] * (md[i][0] ? 259 : 3))
         `CHK(idle_level, md[i][2] ? i[0] : ~i[0])
      end
      done("rates");
      // mid-period divisor writes must push the next tick a full period out
      period(p);
      repeat (500) @(posedge hclk);
      wr(`UBDR_OFS_DIVISOR_LOW, 8'h02);
      to_tick(q);
      `CHK(q > 1000, 1'b1)
      repeat (500) @(posedge hclk);
      wr(`UBDR_OFS_DIVISOR_HIGH, 8'h01);
      to_tick(q);
      `CHK(q > 1000, 1'b1)
      done("restart");
      // enable low: a divisor write is ignored and the tick stays frozen
      @(posedge hclk);
      clk_en <= 1'b0;
      wr(`UBDR_OFS_DIVISOR_LOW, 8'h07);
      repeat (20) @(posedge hclk);
      `CHK(baud_tick, 1'b0)
      clk_en <= 1'b1;
      rdc(`UBDR_OFS_DIVISOR_LOW, 8'h02, 8'hff);
      done("enable");
      // receive: two held, third stalled until a read frees a place
      ubdr_shifter_model_i.push(9'h1a5);
      ubdr_shifter_model_i.push(9'h03c);
      ubdr_shifter_model_i.push(9'h1f0);
      repeat (10) @(posedge hclk);
      `CHK(rx_ready, 1'b0)
      rdc(`UBDR_OFS_RECEIVE_CTRL, 8'h01, 8'h01);
      rdc(`UBDR_OFS_RECEIVE_DATA, 8'ha5, 8'hff);
      rdc(`UBDR_OFS_RECEIVE_CTRL, 8'h00, 8'h01);
      rdc(`UBDR_OFS_RECEIVE_DATA, 8'h3c, 8'hff);
      rdc(`UBDR_OFS_RECEIVE_CTRL, 8'h01, 8'h01);
      rdc(`UBDR_OFS_RECEIVE_DATA, 8'hf0, 8'hff);
      done("receive");
      // transmit with the shifter stalled; a third write is dropped
      ubdr_shifter_model_i.stall <= 1'b1;
      wr(`UBDR_OFS_TRANSMIT_CTRL, 8'h01);
      wr(`UBDR_OFS_TRANSMIT_DATA, 8'h81);
      wr(`UBDR_OFS_TRANSMIT_CTRL, 8'h00);
      wr(`UBDR_OFS_TRANSMIT_DATA, 8'h42);
      wr(`UBDR_OFS_TRANSMIT_DATA, 8'h99);
      repeat (5) @(posedge hclk);
      `CHK(tx_valid, 1'b1)
      ubdr_shifter_model_i.stall <= 1'b0;
      repeat (10) @(posedge hclk);
      `CHK(ubdr_shifter_model_i.tx_got.size(), 2)
      `CHK(ubdr_shifter_model_i.tx_got[0], 9'h181)
      `CHK(ubdr_shifter_model_i.tx_got[1], 9'h042)
      done("transmit");
      // wake: one falling edge flags, the rising edge clears the enable
      wr(`UBDR_OFS_BAUD_CONTROL, 8'h02);
      q = wake_n;
      ubdr_shifter_model_i.send_frame(8'hff, 4);
      repeat (4) @(posedge hclk);
      `CHK(wake_n - q, 1)
      rdc(`UBDR_OFS_BAUD_CONTROL, 8'h00, 8'h02);
      done("wake");
      // auto-rate: enable stays set until the sync character is measured
      wr(`UBDR_OFS_BAUD_CONTROL, 8'h01);
      rdc(`UBDR_OFS_BAUD_CONTROL, 8'h01, 8'h01);
      ubdr_shifter_model_i.send_frame(8'h55, 16);
      repeat (8) @(posedge hclk);
      rdc(`UBDR_OFS_BAUD_CONTROL, 8'h00, 8'h01);
      done("autorate");
      finish_test();
   end
endmodule
